// ===== dv/qrbf_checker.sv
// Port-level assertions for the quadrant bit forcing block.
`timescale 1ns/10ps
module qrbf_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic softReset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic inValid,
   input wire logic [4:0] inStream,
   input wire logic [7:0] inData,
   input wire logic outValid,
   input wire logic [4:0] outStream,
   input wire logic [7:0] outData
);
   // Both resets silence the checks; only the reset check overrides this
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || softReset);

   // Either reset leaves no transfer pending
   reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
      (!rst_n || softReset) |=> !outValid && !s_axi_bvalid && !s_axi_rvalid && s_axi_awready)
      else $error("reset left a transfer pending");
   // One output byte for each input byte, one cycle later
   valid_delay_a: assert property (outValid == $past(inValid))
      else $error("output valid not one cycle after input");
   stream_follow_a: assert property (inValid |=> outStream == $past(inStream))
      else $error("output stream number wrong");
   // Middle six bits are never forced
   mid_bits_a: assert property (inValid |=> outData[6:1] == $past(inData[6:1]))
      else $error("untouched bits of a channel changed");
   data_hold_a: assert property (!inValid |=> $stable(outData))
      else $error("output byte changed without input");
   // Register bus answers
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken during response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_width_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[15:2] >= qrbf_pkg::QF_FIRST_INDEX
      && s_axi_araddr[15:2] <= qrbf_pkg::QF_LAST_INDEX |=> s_axi_rdata[31:12] == 20'h0_0000)
      else $error("read data above the four codes");
endmodule

bind qrbf_top qrbf_checker i_chk (
   .clk(clk), .rst_n(rst_n), .softReset(softReset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .inValid(inValid), .inStream(inStream), .inData(inData),
   .outValid(outValid), .outStream(outStream), .outData(outData)
);

// ===== dv/qrbf_stream_src.sv
// Model of the input side: channel bytes, frame pulses, receiver use.
`timescale 1ns/10ps
module qrbf_stream_src (
   input wire logic clk,
   output logic inValid,
   output logic [4:0] inStream,
   output logic [7:0] inChannel,
   output logic [1:0] inRate,
   output logic [7:0] inData,
   output logic framePulse,
   output logic [31:0] berRxActive
);
   // Idle line; receivers stay off on every stream that forcing may touch
   initial begin
      inValid = 1'b0;
      inStream = 5'h00;
      inChannel = 8'h00;
      inRate = 2'h0;
      inData = 8'h00;
      framePulse = 1'b0;
      berRxActive = 32'h0000_0000;
   end

   // One byte for one cycle; afterwards the data line carries no stale byte
   task automatic send(input logic [4:0] s, input logic [7:0] ch, input logic [1:0] r,
         input logic [7:0] d);
      @(posedge clk);
      inValid <= 1'b1;
      inStream <= s;
      inChannel <= ch;
      inRate <= r;
      inData <= d;
      @(posedge clk);
      inValid <= 1'b0;
      inData <= ~d;
   endtask

   // Frame boundary, one cycle
   task automatic frame();
      @(posedge clk);
      framePulse <= 1'b1;
      @(posedge clk);
      framePulse <= 1'b0;
   endtask
endmodule

// ===== dv/qrbf_top_test.sv
// Self-checking bench for the quadrant bit forcing block.
`timescale 1ns/10ps
module qrbf_top_test;
   logic clk, rst_n, softReset;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, berRxActive;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, inRate;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic inValid, framePulse, outValid;
   logic [4:0] inStream, outStream;
   logic [7:0] inChannel, inData, outChannel, outData;
   int err_total = 0;
   int cmp_count = 0;

   qrbf_top i_dut (.clk(clk), .rst_n(rst_n), .softReset(softReset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .inValid(inValid), .inStream(inStream), .inChannel(inChannel), .inRate(inRate),
      .inData(inData), .framePulse(framePulse), .berRxActive(berRxActive),
      .outValid(outValid), .outStream(outStream), .outChannel(outChannel), .outData(outData));

   // Far side of the stream inputs
   qrbf_stream_src i_src (.clk(clk), .inValid(inValid), .inStream(inStream),
      .inChannel(inChannel), .inRate(inRate), .inData(inData), .framePulse(framePulse),
      .berRxActive(berRxActive));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict, reached from the main sequence or the watchdog
   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Single comparison of a four-state value
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Register write; bready stands from the start until the response is seen
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   // Register read, data and response taken at the answering edge
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
            break;
      end
      s_axi_rready <= 1'b0;
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask

   // Expected byte: quadrant from channel and rate, then the code's action
   function automatic logic [7:0] forced(input logic [11:0] r, input logic [7:0] ch,
         input logic [1:0] rate, input logic [7:0] d);
      logic [2:0] c;
      c = 3'(r >> (3 * (ch >> (3 + rate))));
      forced = d;
      if (c[2] && c[1])
         forced[7] = c[0];
      else if (c[2])
         forced[0] = c[0];
   endfunction

   // One byte through, judged one cycle later
   task automatic pass(input logic [4:0] s, input logic [7:0] ch, input logic [1:0] r,
         input logic [7:0] d, input logic [7:0] e);
      i_src.send(s, ch, r, d);
      #1;
      chk("outValid", 32'h0000_0001, 32'(outValid));
      chk("outData", 32'(e), 32'(outData));
      chk("outChannel", 32'(ch), 32'(outChannel));
   endtask

   // All 32 registers read zero after reset
   task automatic t_reset();
      for (int n = 0; n < 32; n++)
         rd(16'(16'h0480 + 4 * n), 32'h0000_0000, qrbf_pkg::RESP_OKAY);
   endtask

   // Distinct values in every register, read back; bad addresses refused
   task automatic t_regs();
      for (int n = 0; n < 32; n++)
         wr(16'(16'h0480 + 4 * n), 32'(12'hFFF - 12'(n * 37)), qrbf_pkg::RESP_OKAY);
      for (int n = 0; n < 32; n++)
         rd(16'(16'h0480 + 4 * n), 32'(12'hFFF - 12'(n * 37)), qrbf_pkg::RESP_OKAY);
      rd(16'h047C, 32'h0000_0000, qrbf_pkg::RESP_SLVERR);
      wr(16'h0500, 32'h0000_0FFF, qrbf_pkg::RESP_SLVERR);
   endtask

   // Every code in every quadrant, at each quadrant's first and last channel
   task automatic t_codes();
      logic [11:0] r;
      logic [7:0] ch;
      logic [7:0] d;
      for (int rt = 0; rt < 4; rt++) begin
         for (int k = 0; k < 8; k++) begin
            r = {3'(k + 3), 3'(k + 2), 3'(k + 1), 3'(k)};
            wr(16'h048C, 32'(r), qrbf_pkg::RESP_OKAY);
            i_src.frame();
            for (int q = 0; q < 4; q++) begin
               for (int e = 0; e < 2; e++) begin
                  ch = 8'(((q + e) << (3 + rt)) - e);
                  d = (e == 1) ? 8'h7E : 8'h81;
                  pass(5'h03, ch, 2'(rt), d, forced(r, ch, 2'(rt), d));
               end
            end
         end
      end
   endtask

   // Software reset clears codes; new codes wait for the frame boundary
   task automatic t_soft();
      wr(16'h0480, 32'h0000_0FFF, qrbf_pkg::RESP_OKAY);
      i_src.frame();
      pass(5'h00, 8'h00, 2'h0, 8'h00, 8'h80);
      @(posedge clk);
      softReset <= 1'b1;
      @(posedge clk);
      softReset <= 1'b0;
      rd(16'h0480, 32'h0000_0000, qrbf_pkg::RESP_OKAY);
      pass(5'h00, 8'h00, 2'h0, 8'h00, 8'h00);
      wr(16'h0480, 32'h0000_0FFF, qrbf_pkg::RESP_OKAY);
      pass(5'h00, 8'h05, 2'h0, 8'h01, 8'h01);
      // Once latched, only stream 0 forces; no receiver is in use
      i_src.frame();
      rd(16'h0500, 32'h0000_0001, qrbf_pkg::RESP_OKAY);
      rd(16'h0504, 32'h0000_0000, qrbf_pkg::RESP_OKAY);
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      softReset = 1'b0;
      s_axi_awaddr = 16'h0000;
      s_axi_araddr = 16'h0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_codes();
      t_soft();
      stop_test();
   end

   // Hang guard at 20000 cycles, well past the thousand or so cycles the run needs
   initial begin
      #160000;
      err_total++;
      stop_test();
   end
endmodule

// ===== logic/qrbf_force.sv
// Bit forcing of one channel byte by its quadrant code.
`timescale 1ns/10ps
module qrbf_force (
   qrbf_force_if.forcer forceIf
);

   // Pure combinational replacement; other bits always pass
   always_comb begin
      forceIf.forcedData = forceIf.chanData;
      if (forceIf.code[qrbf_pkg::CODE_FORCE_BIT]) begin
         if (forceIf.code[qrbf_pkg::CODE_MSB_BIT]) begin
            // MSB replaced, low seven bits untouched
            forceIf.forcedData[qrbf_pkg::CHAN_W-1] =
               forceIf.code[qrbf_pkg::CODE_VALUE_BIT];
         end else begin
            // LSB replaced, upper seven bits untouched
            forceIf.forcedData[0] = forceIf.code[qrbf_pkg::CODE_VALUE_BIT];
         end
      end
      // Top bit low: byte passes unchanged
   end

endmodule

// ===== logic/qrbf_force_if.sv
// Carrier between the block top and the bit forcing datapath.
`timescale 1ns/10ps
interface qrbf_force_if;
   logic [2:0] code;          // Code of the quadrant of the current channel
   logic [7:0] chanData;      // Channel byte as sampled
   logic [7:0] forcedData;    // Channel byte after forcing

   modport user (output code, output chanData, input forcedData);
   modport forcer (input code, input chanData, output forcedData);
endinterface

// ===== logic/qrbf_pkg.sv
// Constants and types shared by the quadrant bit forcing block.
package qrbf_pkg;

   // Stream and channel geometry
   localparam int unsigned STREAMS = 32;         // Input streams served
   localparam int unsigned STREAM_W = 5;         // Stream number width
   localparam int unsigned CHAN_W = 8;           // Channel byte and channel number width
   localparam int unsigned CODE_W = 3;           // One quadrant code
   localparam int unsigned REG_W = 12;           // Four codes per stream

   // Register indices; byte address is four times the index
   localparam logic [13:0] QF_FIRST_INDEX = 14'h0120;   // Stream 0 quadrant register
   localparam logic [13:0] QF_LAST_INDEX = 14'h013F;    // Stream 31 quadrant register
   localparam logic [13:0] FORCED_MAP_INDEX = 14'h0140; // Streams with forcing active
   localparam logic [13:0] CONFLICT_INDEX = 14'h0141;   // Forcing while receiver in use

   // Field positions of the four codes
   localparam int unsigned Q0_POS = 0;
   localparam int unsigned Q1_POS = 3;
   localparam int unsigned Q2_POS = 6;
   localparam int unsigned Q3_POS = 9;

   // Bits inside one code
   localparam int unsigned CODE_FORCE_BIT = 2;   // Top bit: forcing on
   localparam int unsigned CODE_MSB_BIT = 1;     // Selects MSB rather than LSB
   localparam int unsigned CODE_VALUE_BIT = 0;   // Value written into the chosen bit

   // Reset value of each quadrant register
   localparam logic [11:0] QF_RESET = 12'h000;

   // Stream data rates
   typedef enum logic [1:0] {
      QRBF_RATE_2M = 2'h0,
      QRBF_RATE_4M = 2'h1,
      QRBF_RATE_8M = 2'h2,
      QRBF_RATE_16M = 2'h3
   } qrbf_rate_e;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Address decode result
   typedef enum logic [1:0] {
      QRBF_ADDR_NONE = 2'h0,
      QRBF_ADDR_QF = 2'h1,
      QRBF_ADDR_FORCED = 2'h2,
      QRBF_ADDR_CONFLICT = 2'h3
   } qrbf_addr_kind_e;

   // Write channel states, Gray along idle, one half, response
   typedef enum logic [1:0] {
      QRBF_WR_IDLE = 2'h0,
      QRBF_WR_ADDR = 2'h1,
      QRBF_WR_RESP = 2'h3,
      QRBF_WR_DATA = 2'h2
   } qrbf_wr_state_e;

   // Read channel states
   typedef enum logic {
      QRBF_RD_IDLE = 1'h0,
      QRBF_RD_RESP = 1'h1
   } qrbf_rd_state_e;

endpackage

// ===== logic/qrbf_top.sv
// Quadrant robbed-bit forcing for 32 input streams, with AXI4-Lite registers.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps

// Summary of operation
// - Frame splits into four equal channel quadrants
// - Four 3-bit codes per stream register
// - Top bit clear passes; 10x forces LSB
// - Codes 11x force MSB, others untouched
// - Thirty-two consecutive read/write quadrant registers
module qrbf_top (
   input wire logic clk,                 // Device clock, 125 MHz
   input wire logic rst_n,               // Synchronous reset, active low
   input wire logic softReset,           // Software reset from the unit, active high
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic inValid,             // One channel byte offered this cycle
   input wire logic [4:0] inStream,      // Stream the byte belongs to
   input wire logic [7:0] inChannel,     // Channel counter of that stream
   input wire logic [1:0] inRate,        // Data rate setting of that stream
   input wire logic [7:0] inData,        // Sampled channel byte
   input wire logic framePulse,          // Frame boundary, one cycle
   input wire logic [31:0] berRxActive,  // Receivers in use, one bit per stream
   output logic outValid,
   output logic [4:0] outStream,
   output logic [7:0] outChannel,
   output logic [7:0] outData
);

   // Decode of a byte address into register kind
   function automatic qrbf_pkg::qrbf_addr_kind_e decodeAddr(input logic [15:0] addr);
      logic [13:0] index;
      index = addr[15:2];
      if ((index >= qrbf_pkg::QF_FIRST_INDEX) && (index <= qrbf_pkg::QF_LAST_INDEX)) begin
         decodeAddr = qrbf_pkg::QRBF_ADDR_QF;
      end else if (index == qrbf_pkg::FORCED_MAP_INDEX) begin
         decodeAddr = qrbf_pkg::QRBF_ADDR_FORCED;
      end else if (index == qrbf_pkg::CONFLICT_INDEX) begin
         decodeAddr = qrbf_pkg::QRBF_ADDR_CONFLICT;
      end else begin
         decodeAddr = qrbf_pkg::QRBF_ADDR_NONE;
      end
   endfunction

   // Quadrant of a channel: channel divided by the quadrant size
   function automatic logic [1:0] quadOf(input logic [7:0] chan, input logic [1:0] rate);
      quadOf = 2'h0;
      case (rate)
         qrbf_pkg::QRBF_RATE_2M: quadOf = chan[4:3];   // 8 channels each
         qrbf_pkg::QRBF_RATE_4M: quadOf = chan[5:4];   // 16 channels each
         qrbf_pkg::QRBF_RATE_8M: quadOf = chan[6:5];   // 32 channels each
         qrbf_pkg::QRBF_RATE_16M: quadOf = chan[7:6];  // 64 channels each
         default: quadOf = 2'h0;
      endcase
   endfunction

   // Pick one 3-bit code out of a stream word
   function automatic logic [2:0] pickCode(input logic [11:0] word, input logic [1:0] quad);
      pickCode = 3'h0;
      case (quad)
         2'h0: pickCode = word[qrbf_pkg::Q0_POS +: qrbf_pkg::CODE_W];
         2'h1: pickCode = word[qrbf_pkg::Q1_POS +: qrbf_pkg::CODE_W];
         2'h2: pickCode = word[qrbf_pkg::Q2_POS +: qrbf_pkg::CODE_W];
         2'h3: pickCode = word[qrbf_pkg::Q3_POS +: qrbf_pkg::CODE_W];
         default: pickCode = 3'h0;
      endcase
   endfunction

   // Either reset source clears the whole block
   logic clearAll;                           // Hardware or software reset
   assign clearAll = !rst_n || softReset;

   // Write channel state
   qrbf_pkg::qrbf_wr_state_e wrState_q;      // Current write state
   qrbf_pkg::qrbf_wr_state_e wrState_d;      // Next write state
   logic [15:0] awAddr_q;                    // Address held while data is awaited
   logic [31:0] wData_q;                     // Data held while address is awaited
   logic [3:0] wStrb_q;                      // Strobes held with the data
   logic [1:0] bResp_q;                      // Response of the committed write
   logic awTake;                             // Address handshake this cycle
   logic wTake;                              // Data handshake this cycle
   logic commit;                             // Write lands in the registers now
   logic [15:0] commitAddr;                  // Address of the landing write
   logic [31:0] commitData;                  // Data of the landing write
   logic [3:0] commitStrb;                   // Strobes of the landing write
   qrbf_pkg::qrbf_addr_kind_e commitKind;    // Decoded target of the write

   // Read channel state
   qrbf_pkg::qrbf_rd_state_e rdState_q;      // Current read state
   logic [31:0] rData_q;                     // Captured read data
   logic [1:0] rResp_q;                      // Captured read response
   logic [31:0] readWord;                    // Read mux output
   logic [1:0] readResp;                     // Read mux response

   // Programmed and frame-aligned codes, flip-flop arrays by stream
   logic [11:0] quadCode_q [qrbf_pkg::STREAMS];    // As software wrote them
   logic [11:0] activeCode_q [qrbf_pkg::STREAMS];  // As used by the datapath
   logic [31:0] forcedMap;                         // Streams with any forcing code live

   // Handshake outputs are combinational from the state
   assign s_axi_awready = (wrState_q == qrbf_pkg::QRBF_WR_IDLE) ||
                          (wrState_q == qrbf_pkg::QRBF_WR_DATA);
   assign s_axi_wready = (wrState_q == qrbf_pkg::QRBF_WR_IDLE) ||
                         (wrState_q == qrbf_pkg::QRBF_WR_ADDR);
   assign s_axi_bvalid = (wrState_q == qrbf_pkg::QRBF_WR_RESP);
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = (rdState_q == qrbf_pkg::QRBF_RD_IDLE);
   assign s_axi_rvalid = (rdState_q == qrbf_pkg::QRBF_RD_RESP);
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;

   // A write lands once both halves are in, in either order
   always_comb begin
      commit = 1'b0;
      case (wrState_q)
         qrbf_pkg::QRBF_WR_IDLE: commit = awTake && wTake;
         qrbf_pkg::QRBF_WR_ADDR: commit = wTake;
         qrbf_pkg::QRBF_WR_DATA: commit = awTake;
         default: commit = 1'b0;
      endcase
   end

   // Held halves stand in for the live bus where they arrived earlier
   assign commitAddr = (wrState_q == qrbf_pkg::QRBF_WR_ADDR) ? awAddr_q : s_axi_awaddr;
   assign commitData = (wrState_q == qrbf_pkg::QRBF_WR_DATA) ? wData_q : s_axi_wdata;
   assign commitStrb = (wrState_q == qrbf_pkg::QRBF_WR_DATA) ? wStrb_q : s_axi_wstrb;
   assign commitKind = decodeAddr(commitAddr);

   // Next write state
   always_comb begin
      wrState_d = wrState_q;
      case (wrState_q)
         qrbf_pkg::QRBF_WR_IDLE: begin
            if (awTake && wTake) begin
               wrState_d = qrbf_pkg::QRBF_WR_RESP;
            end else if (awTake) begin
               wrState_d = qrbf_pkg::QRBF_WR_ADDR;
            end else if (wTake) begin
               wrState_d = qrbf_pkg::QRBF_WR_DATA;
            end
         end
         qrbf_pkg::QRBF_WR_ADDR: begin
            if (wTake) begin
               wrState_d = qrbf_pkg::QRBF_WR_RESP;
            end
         end
         qrbf_pkg::QRBF_WR_DATA: begin
            if (awTake) begin
               wrState_d = qrbf_pkg::QRBF_WR_RESP;
            end
         end
         qrbf_pkg::QRBF_WR_RESP: begin
            // Response stands until the master takes it
            if (s_axi_bready) begin
               wrState_d = qrbf_pkg::QRBF_WR_IDLE;
            end
         end
         default: wrState_d = qrbf_pkg::QRBF_WR_IDLE;
      endcase
   end

   // Write state register
   always_ff @(posedge clk) begin
      if (clearAll) begin
         wrState_q <= qrbf_pkg::QRBF_WR_IDLE;
      end else begin
         wrState_q <= wrState_d;
      end
   end

   // Early halves of a write are parked here
   always_ff @(posedge clk) begin
      if (clearAll) begin
         awAddr_q <= 16'h0000;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else begin
         if (awTake) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
      end
   end

   // Write response; status words are read-only, so writes there fail too
   always_ff @(posedge clk) begin
      if (clearAll) begin
         bResp_q <= qrbf_pkg::RESP_OKAY;
      end else if (commit) begin
         if (commitKind == qrbf_pkg::QRBF_ADDR_QF) begin
            bResp_q <= qrbf_pkg::RESP_OKAY;
         end else begin
            bResp_q <= qrbf_pkg::RESP_SLVERR;
         end
      end
   end

   // One pair of code registers per stream
   genvar s;
   generate
      for (s = 0; s < qrbf_pkg::STREAMS; s++) begin : gStream
         logic hit;   // This stream's register is the write target
         assign hit = commit && (commitKind == qrbf_pkg::QRBF_ADDR_QF) &&
                      (commitAddr[6:2] == 5'(s));

         // Programmed codes; byte lanes 0 and 1 carry the 12 bits
         always_ff @(posedge clk) begin
            if (clearAll) begin
               quadCode_q[s] <= qrbf_pkg::QF_RESET;
            end else if (hit) begin
               if (commitStrb[0]) begin
                  quadCode_q[s][7:0] <= commitData[7:0];
               end
               if (commitStrb[1]) begin
                  quadCode_q[s][11:8] <= commitData[11:8];
               end
            end
         end

         // Codes take effect at a frame boundary, so no quadrant is half forced
         always_ff @(posedge clk) begin
            if (clearAll) begin
               activeCode_q[s] <= qrbf_pkg::QF_RESET;
            end else if (framePulse) begin
               activeCode_q[s] <= quadCode_q[s];
            end
         end

         // Stream counts as forcing when any code has its top bit set
         assign forcedMap[s] = activeCode_q[s][qrbf_pkg::Q0_POS + qrbf_pkg::CODE_FORCE_BIT] ||
                               activeCode_q[s][qrbf_pkg::Q1_POS + qrbf_pkg::CODE_FORCE_BIT] ||
                               activeCode_q[s][qrbf_pkg::Q2_POS + qrbf_pkg::CODE_FORCE_BIT] ||
                               activeCode_q[s][qrbf_pkg::Q3_POS + qrbf_pkg::CODE_FORCE_BIT];
      end
   endgenerate

   // Read mux; unmapped addresses read zero with an error response
   always_comb begin
      readWord = 32'h0000_0000;
      readResp = qrbf_pkg::RESP_OKAY;
      case (decodeAddr(s_axi_araddr))
         qrbf_pkg::QRBF_ADDR_QF: begin
            // Bits above the four codes read as zero
            readWord = {20'h0_0000, quadCode_q[s_axi_araddr[6:2]]};
         end
         qrbf_pkg::QRBF_ADDR_FORCED: readWord = forcedMap;
         qrbf_pkg::QRBF_ADDR_CONFLICT: begin
            // Flags a misuse by software; hardware keeps forcing regardless
            readWord = forcedMap & berRxActive;
         end
         default: readResp = qrbf_pkg::RESP_SLVERR;
      endcase
   end

   // Read channel: capture on address, hold until taken
   always_ff @(posedge clk) begin
      if (clearAll) begin
         rdState_q <= qrbf_pkg::QRBF_RD_IDLE;
         rData_q <= 32'h0000_0000;
         rResp_q <= qrbf_pkg::RESP_OKAY;
      end else begin
         case (rdState_q)
            qrbf_pkg::QRBF_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rData_q <= readWord;
                  rResp_q <= readResp;
                  rdState_q <= qrbf_pkg::QRBF_RD_RESP;
               end
            end
            qrbf_pkg::QRBF_RD_RESP: begin
               if (s_axi_rready) begin
                  rdState_q <= qrbf_pkg::QRBF_RD_IDLE;
               end
            end
            default: rdState_q <= qrbf_pkg::QRBF_RD_IDLE;
         endcase
      end
   end

   // Datapath: select the quadrant code and force the byte
   qrbf_force_if forceIf ();
   logic [1:0] inQuad;   // Quadrant of the offered channel
   assign inQuad = quadOf(inChannel, inRate);
   assign forceIf.code = pickCode(activeCode_q[inStream], inQuad);
   assign forceIf.chanData = inData;

   qrbf_force uForce (
      .forceIf(forceIf)
   );

   // One pipeline stage toward the switching memory
   always_ff @(posedge clk) begin
      if (clearAll) begin
         outValid <= 1'b0;
         outStream <= 5'h00;
         outChannel <= 8'h00;
         outData <= 8'h00;
      end else begin
         outValid <= inValid;
         if (inValid) begin
            outStream <= inStream;
            outChannel <= inChannel;
            outData <= forceIf.forcedData;
         end
      end
   end

endmodule
